// ### hdl/sarcc_sar.sv
`timescale 1ns/1ps
module sarcc_sar
    import sarcc_pkg::*;
#(
    parameter int unsigned BITS = 12
) (
    input  wire logic            mclk_i,
    input  wire logic            rst_i,
    input  wire logic            ce_i,
    input  wire logic            start_i,
    input  wire logic [BITS-1:0] held_i,
    output logic                 done_o,
    output logic      [BITS-1:0] result_o
);
    // ----------------------------------------
    // binary search over the held sample
    // ----------------------------------------
    logic [BITS-1:0] trial;
    logic [BITS-1:0] mask;
    logic [BITS-1:0] next_trial;
    logic [BITS-1:0] next_mask;
    logic            next_done;
    logic [BITS-1:0] next_result;
    logic [BITS-1:0] cand;

    initial
    begin
        if (BITS < 2)
            $error("sarcc_sar needs at least two bits");
    end

    always_comb
    begin
        cand        = trial | mask;
        next_trial  = trial;
        next_mask   = mask;
        next_done   = 1'b0;
        next_result = result_o;
        if (ce_i)
        begin
            if (start_i)
            begin
                next_trial = '0;
                next_mask  = {1'b1, {(BITS-1){1'b0}}};
            end
            else if (mask != '0)
            begin
                if (cand <= held_i)
                    next_trial = cand;
                next_mask = mask >> 1;
                if (mask[0])
                begin
                    next_done   = 1'b1;
                    next_result = (cand <= held_i) ? cand : trial;
                end
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            trial    <= '0;
            mask     <= '0;
            done_o   <= 1'b0;
            result_o <= '0;
        end
        else
        begin
            trial    <= next_trial;
            mask     <= next_mask;
            done_o   <= next_done;
            result_o <= next_result;
        end
    end
endmodule : sarcc_sar

// ### hdl/sarcc_sync.sv
`timescale 1ns/1ps
module sarcc_sync #(
    parameter int unsigned WIDTH = 5
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] async_i,
    input  wire logic [WIDTH-1:0] rst_val_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;

    initial
    begin
        if (WIDTH < 1)
            $error("sarcc_sync width must be positive");
    end

    always_comb
    begin
        next_meta = ce_i ? async_i : meta;
        next_sync = ce_i ? meta : sync_o;
    end

    // asynchronous reset takes all-ones; strobes are idle high
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta   <= '1;
            sync_o <= '1;
        end
        else
        begin
            meta   <= next_meta;
            sync_o <= next_sync;
        end
    end
endmodule : sarcc_sync

// ### hdl/sarcc_top.sv
`timescale 1ns/1ps
module sarcc_top
    import sarcc_pkg::*;
#(
    parameter int unsigned RST_CYCLES = SARCC_RST_CYCLES
) (
    input  wire logic                  mclk_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    input  wire logic                  cs_n_i,
    input  wire logic                  rd_n_i,
    input  wire logic                  convert_start_n_i,
    input  wire logic                  byte_sel_i,
    input  wire logic                  power_down_reset_n_i,
    input  wire logic [SARCC_BITS-1:0] analog_code_i,
    output logic                       busy_o,
    output logic                       sampling_o,
    output logic                       power_down_o,
    output sarcc_pkg::sarcc_bus_s      bus_o
);
    import sarcc_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    sarcc_strobe_s pins;
    sarcc_strobe_s pin_s;
    sarcc_strobe_s prev;
    sarcc_strobe_s next_prev;
    logic [SARCC_BITS-1:0] code_meta;
    logic [SARCC_BITS-1:0] code_s;

    assign pins = '{cs_n: cs_n_i, rd_n: rd_n_i, convert_start_n_n: convert_start_n_i,
                    byte_sel: byte_sel_i, pwr_n: power_down_reset_n_i};

    sarcc_sync #(
        .WIDTH ($bits(sarcc_strobe_s))
    ) u_sync (
        .mclk_i    (mclk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .async_i   (pins),
        .rst_val_i ('1),
        .sync_o    (pin_s)
    );

    // analog stand-in code, also two-stage
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            code_meta <= '0;
            code_s    <= '0;
            prev      <= '1;
        end
        else if (ce_i)
        begin
            code_meta <= analog_code_i;
            code_s    <= code_meta;
            prev      <= next_prev;
        end
    end

    assign next_prev = pin_s;

    logic cs_fall;
    logic cv_rise;
    logic cv_fall;
    assign cs_fall = prev.cs_n & ~pin_s.cs_n;
    assign cv_rise = ~prev.convert_start_n_n & pin_s.convert_start_n_n;
    assign cv_fall = prev.convert_start_n_n & ~pin_s.convert_start_n_n;

    // ----------------------------------------
    // sampling and conversion control
    // ----------------------------------------
    localparam int unsigned RCW = $clog2(RST_CYCLES + 1);

    initial
    begin
        if (RST_CYCLES < 1)
            $error("sarcc_top reset phase must be at least one cycle");
    end

    sarcc_state_e          state;
    sarcc_state_e          next_state;
    logic [RCW-1:0]        rst_cnt;
    logic [RCW-1:0]        next_rst_cnt;
    logic [SARCC_BITS-1:0] held;
    logic [SARCC_BITS-1:0] next_held;
    logic                  next_busy;
    logic                  conv_go;
    logic                  sar_done;
    logic [SARCC_BITS-1:0] sar_result;
    logic                  in_reset;
    logic                  next_in_reset;

    always_comb
    begin
        next_state    = state;
        next_rst_cnt  = rst_cnt;
        next_held     = held;
        next_busy     = busy_o;
        next_in_reset = in_reset;
        conv_go       = 1'b0;
        if (!pin_s.pwr_n)
        begin
            if (state != SARCC_RESET && state != SARCC_PDOWN)
            begin
                next_state    = SARCC_RESET;
                next_rst_cnt  = RCW'(RST_CYCLES);
                next_in_reset = 1'b1;
            end
            else if (state == SARCC_RESET)
            begin
                if (rst_cnt <= RCW'(1))
                    next_state = SARCC_PDOWN;
                next_rst_cnt = rst_cnt - RCW'(1);
            end
            next_busy = 1'b0;
        end
        else
        begin
            unique case (state)
                SARCC_RESET, SARCC_PDOWN:
                begin
                    next_state = SARCC_IDLE;
                end
                SARCC_IDLE:
                begin
                    if (cv_rise && !pin_s.cs_n && !busy_o)
                        next_state = SARCC_SAMPLE;
                    else if (cs_fall && pin_s.convert_start_n_n && !busy_o)
                        next_state = SARCC_SAMPLE;
                end
                SARCC_SAMPLE:
                begin
                    if ((cv_fall && !pin_s.cs_n) || (cs_fall && !pin_s.convert_start_n_n))
                    begin
                        conv_go    = 1'b1;
                        next_held  = code_s;
                        next_busy  = 1'b1;
                        next_state = SARCC_CONV;
                    end
                end
                SARCC_CONV:
                begin
                    if (sar_done)
                    begin
                        next_busy     = 1'b0;
                        next_in_reset = 1'b0;
                        if (!pin_s.cs_n && pin_s.convert_start_n_n && prev.convert_start_n_n)
                            next_state = SARCC_SAMPLE;
                        else
                            next_state = SARCC_IDLE;
                    end
                end
                default:
                begin
                    next_state = SARCC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state    <= SARCC_IDLE;
            rst_cnt  <= '0;
            held     <= '0;
            busy_o   <= 1'b0;
            in_reset <= 1'b0;
        end
        else if (ce_i)
        begin
            state    <= next_state;
            rst_cnt  <= next_rst_cnt;
            held     <= next_held;
            busy_o   <= next_busy;
            in_reset <= next_in_reset;
        end
    end

    sarcc_sar #(
        .BITS (SARCC_BITS)
    ) u_sar (
        .mclk_i   (mclk_i),
        .rst_i    (rst_i),
        .ce_i     (ce_i),
        .start_i  (conv_go),
        .held_i   (next_held),
        .done_o   (sar_done),
        .result_o (sar_result)
    );

    // ----------------------------------------
    // output bus
    // ----------------------------------------
    // byte fold packs the low nibble at the top, rest zero
    function automatic logic [11:0] sarcc_fold(input logic [11:0] d, input logic bsel);
        sarcc_fold = bsel ? {d[3:0], 8'h00} : d;
    endfunction : sarcc_fold

    logic                  next_sampling;
    logic                  next_pdown;
    sarcc_bus_s            next_bus;
    logic [SARCC_BITS-1:0] word;

    always_comb
    begin
        // reset phase reports the fixed code until a fresh conversion ends
        word          = in_reset ? SARCC_RESET_CODE : sar_result;
        next_bus.data = sarcc_fold(word, pin_s.byte_sel);
        next_bus.oe   = !pin_s.cs_n && !pin_s.rd_n;
        next_sampling = (next_state == SARCC_SAMPLE);
        next_pdown    = (next_state == SARCC_PDOWN);
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            bus_o        <= '{data: SARCC_RESULT_RST, oe: 1'b0};
            sampling_o   <= 1'b0;
            power_down_o <= 1'b0;
        end
        else if (ce_i)
        begin
            bus_o        <= next_bus;
            sampling_o   <= next_sampling;
            power_down_o <= next_pdown;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_busy_on_start: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ce_i && state == SARCC_SAMPLE && next_state == SARCC_CONV) |=> busy_o)
        else $error("busy did not rise at conversion start");

    a_busy_whole_conv: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state == SARCC_CONV && !sar_done && pin_s.pwr_n) |-> busy_o)
        else $error("busy low during conversion");

    a_busy_falls_done: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ce_i && state == SARCC_CONV && sar_done && pin_s.pwr_n) |=> !busy_o)
        else $error("busy stayed high after completion");

    a_sample_cv_rise: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ce_i && pin_s.pwr_n && state == SARCC_IDLE && cv_rise && !pin_s.cs_n && !busy_o)
        |=> state == SARCC_SAMPLE)
        else $error("convert-start rise did not start sampling");

    a_sample_cs_fall: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ce_i && pin_s.pwr_n && state == SARCC_IDLE && cs_fall && pin_s.convert_start_n_n && !busy_o)
        |=> state == SARCC_SAMPLE)
        else $error("chip-select fall did not start sampling");

    a_conv_on_cv: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ce_i && pin_s.pwr_n && state == SARCC_SAMPLE && cv_fall && !pin_s.cs_n)
        |=> state == SARCC_CONV && held == $past(code_s))
        else $error("convert-start fall did not start conversion");

    a_conv_on_cs: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ce_i && pin_s.pwr_n && state == SARCC_SAMPLE && cs_fall && !pin_s.convert_start_n_n)
        |=> state == SARCC_CONV)
        else $error("chip-select fall did not start conversion");

    a_conv_len: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ce_i && conv_go) ##1 ce_i[*8] |-> busy_o)
        else $error("conversion ended too early");

    a_bus_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
        ce_i |=> bus_o.oe == ($past(!pin_s.cs_n && !pin_s.rd_n)))
        else $error("bus enable not gated by chip select and read");

    a_fold_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ce_i && pin_s.byte_sel) |=> bus_o.data[7:0] == 8'h00)
        else $error("folded low byte not zero");

    a_reset_code: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ce_i && in_reset && !pin_s.byte_sel) |=> bus_o.data == SARCC_RESET_CODE)
        else $error("reset code not shown");

    a_pdown_entry: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state == SARCC_PDOWN) |-> $past(state) inside {SARCC_RESET, SARCC_PDOWN})
        else $error("power-down entered without reset phase");
endmodule : sarcc_top

// ### inc/sarcc_pkg.sv
// Behaviour
// - A low level on power_down_reset_n puts the device into reset, and after a while into power-down.
// - With byte select low the twelve-bit result goes out unchanged; with it high, result bits 3..0 move up to bus bits 11..8.
// - A rising edge of convert_start_n starts sampling when chip select is low and busy is low.
// - A falling edge of chip select starts sampling when convert_start_n is high and busy is low.
// - The internal end of conversion starts sampling, before busy falls, when chip select is low and convert_start_n was already high.
//   The code enters sampling on the same edge that busy falls.
// - A falling edge of convert_start_n with chip select low ends sampling and starts a conversion.
// - A falling edge of chip select with convert_start_n already low ends sampling and starts a conversion.
// - The held input value is the one present on the edge that starts the conversion.
// - Busy rises right after the edge that starts a conversion.
// - Busy stays high for the whole conversion and falls once it has completed.
// - The bus is driven only while chip select and read are both low; otherwise it floats, and the host must assert both to read.
// - With byte select high, bus bits 7..0 read as zero.
// - During the reset phase after power_down_reset_n falls, the output code is FE0 hex.
package sarcc_pkg;

    localparam int unsigned SARCC_BITS         = 12;
    localparam int unsigned SARCC_CLK_PERIOD_NS = 10;
    // successive approximation needs one cycle per bit
    localparam int unsigned SARCC_CONV_CYCLES  = SARCC_BITS;
    // reset phase length before power-down
    localparam int unsigned SARCC_RST_PHASE_NS = 100;
    localparam int unsigned SARCC_RST_CYCLES   =
        (SARCC_RST_PHASE_NS + SARCC_CLK_PERIOD_NS - 1) / SARCC_CLK_PERIOD_NS;
    localparam logic [11:0] SARCC_RESET_CODE   = 12'hFE0;
    localparam logic [11:0] SARCC_RESULT_RST   = 12'h000;

    typedef enum logic [2:0]
    {
        SARCC_IDLE   = 3'b000,
        SARCC_SAMPLE = 3'b001,
        SARCC_CONV   = 3'b010,
        SARCC_RESET  = 3'b011,
        SARCC_PDOWN  = 3'b100
    } sarcc_state_e;

    // host strobes after synchronisation
    typedef struct packed
    {
        logic cs_n;
        logic rd_n;
        logic convert_start_n_n;
        logic byte_sel;
        logic pwr_n;
    } sarcc_strobe_s;

    // data bus pin pair
    typedef struct packed
    {
        logic [11:0] data;
        logic        oe;
    } sarcc_bus_s;

endpackage : sarcc_pkg

// ### tb/sar_adc_conversion_control_bench.sv
`timescale 1ns/1ps
module sar_adc_conversion_control_bench;
    import sarcc_pkg::*;

    logic                  mclk_i = 1'b0;
    logic                  rst_i  = 1'b1;
    logic                  ce     = 1'b1;
    sarcc_strobe_s         req;
    logic [SARCC_BITS-1:0] code;
    logic                  cs_n, rd_n, cvs_n, bsel, pwr_n;
    logic                  busy, samp, pdown;
    sarcc_bus_s            bus;
    logic [SARCC_BITS-1:0] db;
    int                    fail_count = 0;
    int                    tests_run  = 0;

    always #5 mclk_i = ~mclk_i;

    // short reset phase keeps the power-down scenario brief
    sarcc_top #(.RST_CYCLES(2)) dut (
        .mclk_i               (mclk_i),
        .rst_i                (rst_i),
        .ce_i                 (ce),
        .cs_n_i               (cs_n),
        .rd_n_i               (rd_n),
        .convert_start_n_i    (cvs_n),
        .byte_sel_i           (bsel),
        .power_down_reset_n_i (pwr_n),
        .analog_code_i        (code),
        .busy_o               (busy),
        .sampling_o           (samp),
        .power_down_o         (pdown),
        .bus_o                (bus)
    );

    sarcc_host host (
        .mclk_i               (mclk_i),
        .rst_i                (rst_i),
        .req_i                (req),
        .bus_i                (bus),
        .cs_n_o               (cs_n),
        .rd_n_o               (rd_n),
        .convert_start_n_o    (cvs_n),
        .byte_sel_o           (bsel),
        .power_down_reset_n_o (pwr_n),
        .db_o                 (db)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("checks run %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic cycles(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : cycles

    function automatic logic sig(input int sel);
        case (sel)
            0:       return busy;
            1:       return samp;
            2:       return pdown;
            default: return bus.oe;
        endcase
    endfunction : sig

    // bounded wait; running out ends the run
    task automatic wait_on(input int sel, input logic v, input int bound, input string what);
        int n;
        n = 0;
        while (sig(sel) !== v && n < bound)
        begin
            cycles(1);
            n++;
        end
        check(what, {11'h000, sig(sel)}, {11'h000, v});
        if (sig(sel) !== v)
            end_sim();
    endtask : wait_on

    // counts busy from the call, plus cycles already spent high, leaves at its fall
    task automatic busy_len(input string what, input int spent);
        int n;
        n = 0;
        while (busy === 1'b1 && n < 40)
        begin
            cycles(1);
            n++;
        end
        n = n + spent;
        check(what, n[11:0], 12'(SARCC_CONV_CYCLES + 1));
    endtask : busy_len

    task automatic read_check(input logic [11:0] exp);
        req.rd_n = 1'b0;
        wait_on(3, 1'b1, 8, "read enable");
        cycles(1);
        check("plain word", db, exp);
        req.byte_sel = 1'b1;
        cycles(5);
        check("folded word", db, {exp[3:0], 8'h00});
        req.byte_sel = 1'b0;
        cycles(5);
        check("unfolded word", db, exp);
        req.rd_n = 1'b1;
        wait_on(3, 1'b0, 8, "read release");
        check("floating bus", db, ~exp);
    endtask : read_check

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_convert_start_n_path();
        req.cs_n = 1'b0;
        req.convert_start_n_n = 1'b0;
        cycles(5);
        check("no sampling on idle fall", {11'h000, samp}, 12'h000);
        req.convert_start_n_n = 1'b1;
        wait_on(1, 1'b1, 8, "sampling by convert_start_n rise");
        code = 12'hA5C;
        cycles(4);
        req.convert_start_n_n = 1'b0;
        wait_on(0, 1'b1, 8, "busy after convert_start_n fall");
        check("sampling ended", {11'h000, samp}, 12'h000);
        code = 12'h3F1;
        busy_len("busy length convert_start_n", 0);
        read_check(12'hA5C);
    endtask : t_convert_start_n_path

    task automatic t_cs_path();
        code = 12'h7E4;
        req.cs_n = 1'b1;
        req.convert_start_n_n = 1'b1;
        req.rd_n = 1'b0;
        cycles(6);
        check("no drive without select", {11'h000, bus.oe}, 12'h000);
        req.rd_n = 1'b1;
        req.cs_n = 1'b0;
        wait_on(1, 1'b1, 8, "sampling by cs fall");
        req.cs_n = 1'b1;
        cycles(4);
        req.convert_start_n_n = 1'b0;
        cycles(5);
        check("no conversion unselected", {11'h000, busy}, 12'h000);
        req.cs_n = 1'b0;
        wait_on(0, 1'b1, 8, "busy after cs fall");
        // frozen cycles must not count, else busy would end five cycles early
        ce = 1'b0;
        cycles(5);
        ce = 1'b1;
        code = 12'h000;
        busy_len("busy length cs", 0);
        read_check(12'h7E4);
    endtask : t_cs_path

    task automatic t_back_to_back();
        code = 12'h15B;
        req.convert_start_n_n = 1'b1;
        wait_on(1, 1'b1, 8, "sampling first");
        cycles(4);
        req.convert_start_n_n = 1'b0;
        wait_on(0, 1'b1, 8, "busy first");
        cycles(1);
        req.convert_start_n_n = 1'b1;
        code = 12'h8C6;
        cycles(5);
        check("no sampling while busy", {11'h000, samp}, 12'h000);
        busy_len("busy length first", 6);
        wait_on(1, 1'b1, 2, "sampling at conversion end");
        cycles(4);
        req.convert_start_n_n = 1'b0;
        wait_on(0, 1'b1, 8, "busy second");
        busy_len("busy length second", 0);
        read_check(12'h8C6);
    endtask : t_back_to_back

    task automatic t_power();
        req.rd_n = 1'b0;
        req.pwr_n = 1'b0;
        wait_on(2, 1'b1, 12, "power down entered");
        check("reset code", db, SARCC_RESET_CODE);
        check("idle in power down", {10'h000, busy, samp}, 12'h000);
        req.pwr_n = 1'b1;
        wait_on(2, 1'b0, 12, "power down left");
        req.rd_n = 1'b1;
        cycles(4);
    endtask : t_power

    initial
    begin
        req  = '{cs_n: 1'b1, rd_n: 1'b1, convert_start_n_n: 1'b1, byte_sel: 1'b0, pwr_n: 1'b1};
        code = 12'h000;
        cycles(3);
        rst_i = 1'b0;
        cycles(1);
        check("state after reset", {8'h00, busy, samp, pdown, bus.oe}, 12'h000);
        t_convert_start_n_path();
        t_cs_path();
        t_back_to_back();
        t_power();
        end_sim();
    end

endmodule : sar_adc_conversion_control_bench

// ### tb/sarcc_host.sv
`timescale 1ns/1ps
module sarcc_host
    import sarcc_pkg::*;
(
    input  wire logic                  mclk_i,
    input  wire logic                  rst_i,
    input  wire sarcc_pkg::sarcc_strobe_s req_i,
    input  wire sarcc_pkg::sarcc_bus_s    bus_i,
    output logic                       cs_n_o,
    output logic                       rd_n_o,
    output logic                       convert_start_n_o,
    output logic                       byte_sel_o,
    output logic                       power_down_reset_n_o,
    output logic      [SARCC_BITS-1:0] db_o
);
    import sarcc_pkg::*;

    logic [SARCC_BITS-1:0] last;
    logic [SARCC_BITS-1:0] next_last;

    // ------------------------------------------------------------
    // strobes
    // ------------------------------------------------------------
    // a read needs both selects low
    assign cs_n_o               = req_i.cs_n;
    assign rd_n_o               = req_i.rd_n;
    assign convert_start_n_o    = req_i.convert_start_n_n;
    assign byte_sel_o           = req_i.byte_sel;
    assign power_down_reset_n_o = req_i.pwr_n;

    // ------------------------------------------------------------
    // data bus resolution
    // ------------------------------------------------------------
    // a floating bus must not keep showing the last word
    always_comb
    begin
        next_last = last;
        if (bus_i.oe)
        begin
            next_last = bus_i.data;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            last <= 12'h000;
        end
        else
        begin
            last <= next_last;
        end
    end

    assign db_o = bus_i.oe ? bus_i.data : ~last;

endmodule : sarcc_host
